/* rtl/pirc_pkg.sv */
package pirc_pkg;

    // Register indices as numbered in the map; byte address is four times
    localparam logic [7:0] IDX_DEVICE_IDENTITY  = 8'h00;
    localparam logic [7:0] IDX_SILICON_REVISION = 8'h01;
    localparam logic [7:0] IDX_EMUL_REV_PROG_HI = 8'h02;
    localparam logic [7:0] IDX_PROGRAM_ID_LOW   = 8'h03;
    localparam logic [7:0] IDX_CONFIG_CTRL      = 8'h04;
    localparam logic [7:0] IDX_EVENT_FLAGS      = 8'h05;
    localparam logic [7:0] IDX_BACKUP_SCRATCH   = 8'h06;
    localparam logic [7:0] IDX_FUSE_MIRROR      = 8'h07;

    // Index field inside a byte address
    localparam int unsigned IDX_LSB = 2;
    localparam int unsigned IDX_MSB = 9;

    // Reset values and field positions
    localparam logic [7:0] CTRL_RST       = 8'h00;
    localparam logic [7:0] FLAGS_RST      = 8'h00;
    localparam logic [7:0] BACKUP_RST     = 8'h00;
    localparam logic [7:0] MIRROR_RST     = 8'h00;
    localparam logic [11:0] PROGRAM_IDENTITY_LOW_RST   = 12'h000;
    localparam logic [31:0] RDATA_RST     = 32'h0000_0000;
    localparam logic [3:0] CTRL_HI_RST    = 4'h0;
    localparam int unsigned CTRL_CAPT_EN  = 7;
    localparam logic       RESERVED_BIT   = 1'b0;
    localparam logic [23:0] UPPER_ZERO    = 24'h00_0000;

    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;

    // Fuse bank contents presented by the fuse controller
    typedef struct packed {
        logic [11:0] fuse_program_identifier;
        logic [3:0]  ctrl_default;
        logic [7:0]  mirror_word;
    } pirc_fuse_s;

    // Trim values set at manufacture
    typedef struct packed {
        logic [3:0] part_number_field;
        logic [3:0] base_layer_revision;
        logic [3:0] interconnect_layer_revision;
        logic [2:0] emulation_revision;
    } pirc_trim_s;

    // Supply monitor levels, all synchronous to hclk
    typedef struct packed {
        logic input_undervoltage_threshold;
        logic backup_supply_rail;
        logic off_state_entry;
    } pirc_supply_s;

    // Word index of a byte address
    function automatic logic [7:0] pirc_index(input logic [31:0] addr);
        return addr[IDX_MSB:IDX_LSB];
    endfunction

endpackage

/* rtl/pirc_regs.sv */
// Our own choice: the AHB-Lite register port.
`timescale 1ns/100ps

// Functional notes
// - Undervoltage class resets when input below threshold
// - Fuse-mirror bits copy the programmed fuse contents
// - Off-state class resets on entry to off
// - Backup-loss class resets when input and rail lost
// - Flags read back; writing one clears them
// - Zero-default bits are driven to zero
// - F-default bits take reset value from fuses
module pirc_regs
    import pirc_pkg::*;
#(
    // Arbitrary neutral part family code
    parameter logic [3:0] PART_FAMILY = 4'h9
)(
    // Clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // AHB-Lite slave
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic      [31:0]  hrdata,
    output logic              hreadyout,
    output logic              hresp,
    // Device side
    input  wire pirc_fuse_s   fuse,
    input  wire logic         fuse_load,
    input  wire pirc_trim_s   trim,
    input  wire pirc_supply_s supply,
    input  wire logic [7:0]   event_in,
    output logic      [7:0]   config_ctrl,
    output logic      [7:0]   event_flags
);

    // Reset class conditions. Each class is cleared by its own trigger
    // only (besides hresetn): a flag wiped by the wrong event looks to
    // software like a lost event, which is harder to chase than a stuck
    // one. The monitors give levels, so a held condition simply keeps
    // its class at the default for as long as it lasts.
    logic uv_reset;
    logic off_reset;
    logic backup_reset;

    assign uv_reset     = supply.input_undervoltage_threshold;
    assign off_reset    = supply.off_state_entry;
    assign backup_reset = supply.input_undervoltage_threshold
                          && !supply.backup_supply_rail;

    // Bus state
    logic        wr_pend_ff;
    logic        nxt_wr_pend;
    logic [7:0]  wr_idx_ff;
    logic [7:0]  nxt_wr_idx;
    logic [31:0] hrdata_ff;
    logic [31:0] nxt_hrdata;
    logic        hreadyout_ff;
    logic        nxt_hreadyout;
    logic        hresp_ff;
    logic        nxt_hresp;

    // Register state: copies of the fuse bank, then the software words,
    // each of which belongs to exactly one reset class
    logic        fuse_pend_ff;
    logic        nxt_fuse_pend;
    logic [11:0] program_identity_low_ff;
    logic [11:0] nxt_program_identity_low;
    logic [7:0]  mirror_ff;
    logic [7:0]  nxt_mirror;
    logic [7:0]  ctrl_ff;
    logic [7:0]  nxt_ctrl;
    logic [7:0]  flags_ff;
    logic [7:0]  nxt_flags;
    logic [7:0]  backup_ff;
    logic [7:0]  nxt_backup;
    logic        fuse_reload;
    logic        ctrl_reload;
    logic        capture_en;

    logic        addr_take;
    logic        wr_now;
    logic [7:0]  wbyte;

    assign addr_take = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign wr_now    = wr_pend_ff;
    assign wbyte     = hwdata[7:0];

    // Fuse copy is refreshed after reset, on request and on off entry;
    // the control word has no separate load request of its own
    assign fuse_reload = fuse_pend_ff || fuse_load || off_reset;
    assign ctrl_reload = fuse_pend_ff || off_reset;

    // Capture enable comes from the registered word, so an event in the
    // cycle whose write sets it is not yet flagged
    assign capture_en  = ctrl_ff[CTRL_CAPT_EN];

    // Data phase of a write to the given word; the index was latched in
    // the address phase because haddr already belongs to the next one
    function automatic logic wr_hit(input logic [7:0] idx);
        return wr_now && (wr_idx_ff == idx);
    endfunction

    // Read mux for a register index; unmapped words read zero. The
    // identity words have no write path at all, so a stray write to
    // them cannot disturb what software uses to recognise the part.
    function automatic logic [7:0] rd_byte(input logic [7:0] idx);
        logic [7:0] v;
        v = 8'h00;
        unique case (idx)
            IDX_DEVICE_IDENTITY:  v = {PART_FAMILY, trim.part_number_field};
            IDX_SILICON_REVISION: v = {trim.base_layer_revision,
                                       trim.interconnect_layer_revision};
            IDX_EMUL_REV_PROG_HI: v = {program_identity_low_ff[11:8], RESERVED_BIT,
                                       trim.emulation_revision};
            IDX_PROGRAM_ID_LOW:   v = program_identity_low_ff[7:0];
            IDX_CONFIG_CTRL:      v = ctrl_ff;
            IDX_EVENT_FLAGS:      v = flags_ff;
            IDX_BACKUP_SCRATCH:   v = backup_ff;
            IDX_FUSE_MIRROR:      v = mirror_ff;
            default:              v = 8'h00;
        endcase
        return v;
    endfunction

    // Address phase capture; zero wait states so read data is set up
    // at the address edge and stands through the data phase. A read of
    // a word whose write is still in its data phase returns the old
    // value; software that needs the new one reads it again.
    always_comb
    begin
        nxt_wr_pend   = addr_take && hwrite;
        nxt_wr_idx    = addr_take ? pirc_index(haddr) : wr_idx_ff;
        nxt_hrdata    = hrdata_ff;
        nxt_hreadyout = 1'b1; // Zero wait states
        nxt_hresp     = HRESP_OKAY; // No error path
        if (addr_take && !hwrite)
        begin
            nxt_hrdata = {UPPER_ZERO, rd_byte(pirc_index(haddr))};
        end
    end

    // Bus flops; hreadyout is low in reset, so no transfer is taken
    // before the first edge after release has loaded the fuse copy
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_ff   <= 1'b0;
            wr_idx_ff    <= IDX_DEVICE_IDENTITY;
            hrdata_ff    <= RDATA_RST;
            hreadyout_ff <= 1'b0;
            hresp_ff     <= HRESP_OKAY;
        end
        else
        begin
            wr_pend_ff   <= nxt_wr_pend;
            wr_idx_ff    <= nxt_wr_idx;
            hrdata_ff    <= nxt_hrdata;
            hreadyout_ff <= nxt_hreadyout;
            hresp_ff     <= nxt_hresp;
        end
    end

    // Fuse-loaded contents: reloaded after reset release, on request
    // and on entry to off. Async reset may only load constants, so the
    // fuse copy waits for the first edge after release.
    always_comb
    begin
        nxt_fuse_pend = 1'b0;
        nxt_program_identity_low   = program_identity_low_ff;
        nxt_mirror    = mirror_ff;
        if (fuse_reload)
        begin
            nxt_program_identity_low = fuse.fuse_program_identifier;
            nxt_mirror  = fuse.mirror_word;
        end
        // Writes to identity and mirror words are dropped here
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fuse_pend_ff <= 1'b1;
            program_identity_low_ff   <= PROGRAM_IDENTITY_LOW_RST;
            mirror_ff    <= MIRROR_RST;
        end
        else
        begin
            fuse_pend_ff <= nxt_fuse_pend;
            program_identity_low_ff   <= nxt_program_identity_low;
            mirror_ff    <= nxt_mirror;
        end
    end

    // Control word: off-state class, upper nibble defaults to zero,
    // lower nibble to the fuse default. The capture enable sits in the
    // upper nibble, so it comes up off and no event is flagged before
    // software has set things up.
    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        if (wr_hit(IDX_CONFIG_CTRL))
        begin
            nxt_ctrl = wbyte;
        end
        // A reload beats a write landing in the same cycle
        if (ctrl_reload)
        begin
            nxt_ctrl = {CTRL_HI_RST, fuse.ctrl_default};
        end
    end

    // Off-state class register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_ff <= CTRL_RST;
        end
        else
        begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // Event flags: undervoltage class; a new event beats a clear in
    // the same cycle so no event is lost
    always_comb
    begin
        nxt_flags = flags_ff;
        // Later assignments win: clear, then capture, then the class
        // reset, so an event beats a clear but never an undervoltage
        if (wr_hit(IDX_EVENT_FLAGS))
        begin
            nxt_flags = flags_ff & ~wbyte;
        end
        if (capture_en)
        begin
            nxt_flags = nxt_flags | event_in;
        end
        if (uv_reset)
        begin
            nxt_flags = FLAGS_RST;
        end
    end

    // Undervoltage class register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            flags_ff <= FLAGS_RST;
        end
        else
        begin
            flags_ff <= nxt_flags;
        end
    end

    // Scratch word that survives everything but hresetn and loss of both supplies;
    // an undervoltage dip with the backup rail still present leaves it
    always_comb
    begin
        nxt_backup = backup_ff;
        if (wr_hit(IDX_BACKUP_SCRATCH))
        begin
            nxt_backup = wbyte;
        end
        if (backup_reset)
        begin
            nxt_backup = BACKUP_RST;
        end
    end

    // Backup-loss class register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            backup_ff <= BACKUP_RST;
        end
        else
        begin
            backup_ff <= nxt_backup;
        end
    end

    // Outputs straight from flops, hresp included, so that every port
    // has the same clock-to-output timing
    assign hrdata      = hrdata_ff;
    assign hreadyout   = hreadyout_ff;
    assign hresp       = hresp_ff;
    assign config_ctrl = ctrl_ff;
    assign event_flags = flags_ff;

endmodule // pirc_regs

/* tb/pirc_regs_assertions.sv */
`timescale 1ns/100ps

// Watches the register bank from its ports only
module pirc_regs_assertions
    import pirc_pkg::*;
#(
    parameter logic [3:0] PART_FAMILY = 4'h9
)(
    // Clock and reset
    input wire logic         hclk,
    input wire logic         hresetn,
    // Bus
    input wire logic         hsel,
    input wire logic [31:0]  haddr,
    input wire logic [1:0]   htrans,
    input wire logic         hwrite,
    input wire logic [31:0]  hwdata,
    input wire logic         hready,
    input wire logic [31:0]  hrdata,
    input wire logic         hreadyout,
    input wire logic         hresp,
    // Device side
    input wire pirc_fuse_s   fuse,
    input wire logic         fuse_load,
    input wire pirc_trim_s   trim,
    input wire pirc_supply_s supply,
    input wire logic [7:0]   event_in,
    input wire logic [7:0]   config_ctrl,
    input wire logic [7:0]   event_flags
);
    logic       take;
    logic       rd;
    logic       wr_ff;
    logic [7:0] idx_ff;

    // Transfer taken this edge
    assign take = hsel && hready && htrans == HTRANS_NONSEQ;
    assign rd   = take && !hwrite;

    // Remember which write has its data phase next
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_ff  <= 1'b0;
            idx_ff <= 8'h00;
        end
        else if (hready)
        begin
            wr_ff  <= take && hwrite;
            idx_ff <= pirc_index(haddr);
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_uv_clears_flags:
    assert property (supply.input_undervoltage_threshold |=>
        event_flags == FLAGS_RST) else $error("flags kept past undervoltage");
    a_off_loads_ctrl:
    assert property (supply.off_state_entry |=> config_ctrl ==
        {CTRL_HI_RST, $past(fuse.ctrl_default)}) else $error("ctrl not reloaded");
    a_ctrl_holds:
    assert property ($past(hresetn) && !supply.off_state_entry &&
        !(wr_ff && idx_ff == IDX_CONFIG_CTRL) |=> $stable(config_ctrl))
        else $error("ctrl changed without cause");
    a_flags_hold:
    assert property (!supply.input_undervoltage_threshold && event_in == 8'h00
        && !(wr_ff && idx_ff == IDX_EVENT_FLAGS) |=> $stable(event_flags))
        else $error("flags changed without cause");
    a_flag_clear:
    assert property (wr_ff && idx_ff == IDX_EVENT_FLAGS && event_in == 8'h00
        && !supply.input_undervoltage_threshold |=> event_flags ==
        ($past(event_flags) & ~$past(hwdata[7:0]))) else $error("bad clear");
    a_id_read:
    assert property (rd && pirc_index(haddr) == IDX_DEVICE_IDENTITY |=> hrdata
        == {UPPER_ZERO, PART_FAMILY, $past(trim.part_number_field)})
        else $error("identity read wrong");
    a_rev_read:
    assert property (rd && pirc_index(haddr) == IDX_SILICON_REVISION |=>
        hrdata[7:0] == {$past(trim.base_layer_revision),
        $past(trim.interconnect_layer_revision)}) else $error("revision wrong");
    a_mirror_read:
    assert property (rd && pirc_index(haddr) == IDX_FUSE_MIRROR && $stable(fuse)
        && $past(fuse_load) && $past(hresetn) |=> hrdata[7:0] ==
        $past(fuse.mirror_word)) else $error("mirror differs from fuses");

    a_bus_answers:
    assert property ($past(hresetn) |-> hreadyout && hresp == HRESP_OKAY)
        else $error("bus not answering okay");

    // Main scenarios reached
    cover property (wr_ff && idx_ff == IDX_EVENT_FLAGS);
    cover property (supply.off_state_entry);
    cover property (supply.input_undervoltage_threshold
        && !supply.backup_supply_rail);
endmodule // pirc_regs_assertions

bind pirc_regs pirc_regs_assertions #(.PART_FAMILY(PART_FAMILY))
    pirc_regs_assertions_inst (.*);

/* tb/pirc_regs_test.sv */
`timescale 1ns/100ps

// Self-checking bench for the register bank
module pirc_regs_test
    import pirc_pkg::*;
;
    localparam logic [3:0] FAM = 4'h6; // Arbitrary family code
    typedef struct packed {
        logic [31:0] a;
        logic [7:0]  w;
        logic [7:0]  e;
    } pirc_row_s;

    logic         hclk = 1'b0;
    logic         hresetn;
    logic         hsel;
    logic [31:0]  haddr;
    logic [1:0]   htrans;
    logic         hwrite;
    logic [31:0]  hwdata;
    logic [31:0]  hrdata;
    logic         hreadyout;
    logic         hresp;
    pirc_fuse_s   fuse;
    logic         fuse_load;
    pirc_trim_s   trim;
    pirc_supply_s supply;
    logic [7:0]   event_in;
    logic [7:0]   config_ctrl;
    logic [7:0]   event_flags;
    logic [31:0]  q;
    int           num_errors = 0;
    int           n_compared = 0;
    // Write each row, read it back; read-only writes must not stick
    pirc_row_s    rows [7] = '{'{32'h0000_0000, 8'hff, {FAM, 4'h2}},
        '{32'h0000_0004, 8'h00, 8'h3a}, '{32'h0000_0008, 8'h00, 8'hb6},
        '{32'h0000_000c, 8'hff, 8'h7c}, '{32'h0000_001c, 8'h00, 8'h5e},
        '{32'h0000_0020, 8'h55, 8'h00}, '{32'h0000_0010, 8'h85, 8'h85}};

    pirc_regs #(.PART_FAMILY(FAM)) pirc_regs_inst (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fuse(fuse),
        .fuse_load(fuse_load), .trim(trim), .supply(supply),
        .event_in(event_in), .config_ctrl(config_ctrl),
        .event_flags(event_flags));

    // 100 MHz clock
    always #5 hclk = ~hclk;

    task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    end
    endtask

    // One single transfer; waits on hready rather than assuming zero wait
    task bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    begin
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        haddr  <= a;
        do @(posedge hclk);
        while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk);
        while (hreadyout !== 1'b1);
        q = hrdata;
        chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
    end
    endtask

    task rd(input logic [31:0] a, input logic [7:0] e);
    begin
        bus(1'b0, a, 32'h0000_0000);
        chk(q, {24'h00_0000, e});
    end
    endtask

    // One-cycle supply event, then back to normal (rail present)
    task pulse(input pirc_supply_s s);
    begin
        @(posedge hclk);
        supply <= s;
        @(posedge hclk);
        supply <= 3'h2;
    end
    endtask

    task end_of_test;
    begin
        if (num_errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask

    // Main sequence
    initial
    begin
        {hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
        {fuse_load, event_in} = '0;
        fuse   = '{12'hb7c, 4'hd, 8'h5e};
        trim   = '{4'h2, 4'h3, 4'ha, 3'h6};
        supply = 3'h2;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (rows[i])
        begin
            bus(1'b1, rows[i].a, {24'h00_0000, rows[i].w});
            rd(rows[i].a, rows[i].e);
        end
        @(posedge hclk);
        event_in <= 8'ha5;
        @(posedge hclk);
        event_in <= 8'h00;
        rd(32'h0000_0014, 8'ha5);
        bus(1'b1, 32'h0000_0014, 32'h0000_0081);
        rd(32'h0000_0014, 8'h24);
        bus(1'b1, 32'h0000_0018, 32'h0000_003c);
        pulse(3'h6);
        rd(32'h0000_0018, 8'h3c);
        chk({24'h00_0000, event_flags}, 32'h0000_0000);
        rd(32'h0000_0010, 8'h85);
        pulse(3'h4);
        rd(32'h0000_0018, 8'h00);
        @(posedge hclk);
        fuse      <= '{12'h4e1, 4'h9, 8'hc3};
        fuse_load <= 1'b1;
        rd(32'h0000_001c, 8'hc3);
        rd(32'h0000_000c, 8'he1);
        @(posedge hclk);
        fuse_load <= 1'b0;
        rd(32'h0000_0010, 8'h85);
        pulse(3'h3);
        rd(32'h0000_0010, 8'h09);
        // Second reset in mid-run
        @(posedge hclk);
        hresetn <= 1'b0;
        @(posedge hclk);
        chk({16'h0000, config_ctrl, event_flags}, 32'h0000_0000);
        hresetn <= 1'b1;
        rd(32'h0000_0010, 8'h09);
        end_of_test;
    end

    // Watchdog: the sequence needs well under a thousand cycles
    initial
    begin
        repeat (3000) @(posedge hclk);
        num_errors++;
        end_of_test;
    end
endmodule // pirc_regs_test
